// >>> hdl/sai_top.sv
/*
  Sensor digital control: register file, threshold and data-ready flags,
  sleep/measure sequencing, two-wire slave port and the alert pin.
  Assumes the converter pulses convDone with fresh data on core_clk and
  that the bus pins are pulled up outside; bus pins are asynchronous.
*/
// Functional notes
// (R1) alert pin follows one selected source, never an OR of several
// (R2) priority: temp over, temp under, humid over, humid under
// (R3) data-ready takes the winner's priority level; code puts it last, after all four threshold sources
// (R4) conversion end sets data-ready flag when its mask bit is set
// (R5) pin driven only with pin enable 1 and mode bit 0
// (R6) otherwise pin stays released regardless of flags
// (R7) polarity bit 0 means active low pin
// (R8) reading the flag register clears pending indication
// (R9) temp above upper limit sets temp over flag when enabled
// (R10) temp below lower limit sets temp under flag when enabled
// (R11) humidity above upper limit sets humid over flag when enabled
// (R12) humidity below lower limit sets humid under flag when enabled
// (R13) mode 0: threshold flags stay set until read
// (R14) mode 1: threshold flags follow latest conversion
// (R15) sleep after reset, trigger measures, stores data, sleeps again
// (R16) host waits 3.5 ms after power-up before measuring
// (R17) address low bit taken from address select pin
// (R18) address select pin fixed before and during bus use
// (R19) bytes move MSB first; device is slave only
// (R20) first written byte after address loads the pointer
// (R21) reads use last written pointer; repeated start to read
// (R22) pointer auto-increments; NACK read-only, unused, wrong address
module sai_top #(
  parameter logic [15:0] MFR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h5678  // arbitrary value
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // two-wire bus pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // address select strap
  input  wire logic        addrSel,
  // converter
  input  wire logic        convDone,
  input  wire logic [15:0] tempData,
  input  wire logic [15:0] humidData,
  output logic             measStart,
  output logic             measBusy,
  // alert pin
  output logic             alertOut,
  output logic             alertOe
);
  logic [2:0]       syncPins;
  logic             sclS;
  logic             sdaS;
  logic             addrS;
  logic             sclP_ff;
  logic             sdaP_ff;
  logic             sclRise;
  logic             sclFall;
  logic             startCond;
  logic             stopCond;
  logic [1:0]       addrCnt_ff;
  logic             addrLow_ff;
  logic [6:0]       devAddr;
  sai_pkg::sai_bus_t busState_ff;
  sai_pkg::sai_bus_t ackNext_ff;
  logic [3:0]       bitCnt_ff;
  logic [7:0]       shReg_ff;
  logic [7:0]       txSh_ff;
  logic [7:0]       ptr_ff;
  logic             rdMode_ff;
  logic             mackOk_ff;
  logic             byteDone;
  logic             loadByte;
  logic             statusRead;
  logic             wrEn;
  logic [7:0]       rdData;
  logic [7:0]       rwRegs_ff [sai_pkg::RW_LO:sai_pkg::RW_HI];
  logic [15:0]      tempReg_ff;
  logic [15:0]      humReg_ff;
  logic [7:0]       tempMax_ff;
  logic [7:0]       humMax_ff;
  logic [7:0]       flags_ff;
  logic [7:0]       nxt_flags;
  logic [7:0]       mask;
  logic [7:0]       ctrl;
  logic [3:0]       cmpHit;
  logic             convTake;
  logic             measTrig;
  sai_pkg::sai_meas_t measState_ff;

  // register map decoding
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a <= sai_pkg::REG_MEAS_CFG) || (a >= sai_pkg::REG_MFR_LO);
  endfunction : isMapped

  function automatic logic isWritable(input logic [7:0] a);
    isWritable = (a >= sai_pkg::REG_MASK) && (a <= sai_pkg::REG_MEAS_CFG);
  endfunction : isWritable

  sai_sync #(.W(3)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  ({sclIn, sdaIn, addrSel}),
    .syncOut  (syncPins)
  );
  assign sclS  = syncPins[2];
  assign sdaS  = syncPins[1];
  assign addrS = syncPins[0];

  // strap sampled on the first three cycles after reset release, then held
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addrCnt_ff <= 2'h0;
      addrLow_ff <= 1'b0;
    end else if (addrCnt_ff != sai_pkg::ADDR_SETTLE) begin
      addrCnt_ff <= addrCnt_ff + 2'h1;
      addrLow_ff <= addrS; // (R17)
    end
  end
  assign devAddr = {sai_pkg::ADDR_BASE[6:1], addrLow_ff}; // (R17)

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclP_ff <= 1'b1;
      sdaP_ff <= 1'b1;
    end else begin
      sclP_ff <= sclS;
      sdaP_ff <= sdaS;
    end
  end
  assign sclRise   = sclS & ~sclP_ff;
  assign sclFall   = ~sclS & sclP_ff;
  assign startCond = sclS & sclP_ff & sdaP_ff & ~sdaS;
  assign stopCond  = sclS & sclP_ff & ~sdaP_ff & sdaS;
  assign byteDone  = sclFall && (bitCnt_ff == sai_pkg::BYTE_BITS);
  assign loadByte  = sclFall && mackOk_ff && (busState_ff == sai_pkg::BS_MACK
                     || (busState_ff == sai_pkg::BS_ACK
                         && ackNext_ff == sai_pkg::BS_RDAT));
  assign statusRead = loadByte && (ptr_ff == sai_pkg::REG_FLAGS);
  assign wrEn = (busState_ff == sai_pkg::BS_WDAT) && byteDone
                && isWritable(ptr_ff);

  // slave byte engine
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busState_ff <= sai_pkg::BS_IDLE;
      ackNext_ff  <= sai_pkg::BS_IDLE;
      bitCnt_ff   <= 4'h0;
      shReg_ff    <= 8'h00;
      txSh_ff     <= 8'h00;
      ptr_ff      <= 8'h00;
      rdMode_ff   <= 1'b0;
      mackOk_ff   <= 1'b0;
      sdaOe       <= 1'b0;
    end else if (stopCond) begin
      busState_ff <= sai_pkg::BS_IDLE;
      sdaOe       <= 1'b0;
    end else if (startCond) begin
      busState_ff <= sai_pkg::BS_ADDR;
      bitCnt_ff   <= 4'h0;
      sdaOe       <= 1'b0;
    end else begin
      case (busState_ff)
        sai_pkg::BS_ADDR, sai_pkg::BS_PTR, sai_pkg::BS_WDAT: begin
          if (sclRise) begin
            shReg_ff  <= {shReg_ff[6:0], sdaS}; // (R19)
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end else if (byteDone) begin
            bitCnt_ff <= 4'h0;
            if (busState_ff == sai_pkg::BS_ADDR) begin
              if (shReg_ff[7:1] == devAddr) begin
                sdaOe       <= 1'b1;
                busState_ff <= sai_pkg::BS_ACK;
                rdMode_ff   <= shReg_ff[0];
                mackOk_ff   <= shReg_ff[0];
                ackNext_ff  <= shReg_ff[0] ? sai_pkg::BS_RDAT
                                           : sai_pkg::BS_PTR;
              end else begin
                busState_ff <= sai_pkg::BS_IDLE; // (R22)
              end
            end else if (busState_ff == sai_pkg::BS_PTR) begin
              if (isMapped(shReg_ff)) begin
                ptr_ff      <= shReg_ff; // (R20)
                sdaOe       <= 1'b1;
                busState_ff <= sai_pkg::BS_ACK;
                ackNext_ff  <= sai_pkg::BS_WDAT;
              end else begin
                busState_ff <= sai_pkg::BS_IDLE; // (R22)
              end
            end else if (isWritable(ptr_ff)) begin
              ptr_ff      <= ptr_ff + 8'h01; // (R22)
              sdaOe       <= 1'b1;
              busState_ff <= sai_pkg::BS_ACK;
              ackNext_ff  <= sai_pkg::BS_WDAT;
            end else begin
              busState_ff <= sai_pkg::BS_IDLE; // (R22)
            end
          end
        end
        sai_pkg::BS_ACK: begin
          if (sclFall) begin
            busState_ff <= ackNext_ff;
            if (loadByte) begin
              txSh_ff <= rdData; // (R21)
              sdaOe   <= ~rdData[7]; // (R19)
              ptr_ff  <= ptr_ff + 8'h01; // (R22)
            end else begin
              sdaOe <= 1'b0;
            end
          end
        end
        sai_pkg::BS_RDAT: begin
          if (sclRise) begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end else if (byteDone) begin
            sdaOe       <= 1'b0;
            bitCnt_ff   <= 4'h0;
            busState_ff <= sai_pkg::BS_MACK;
          end else if (sclFall) begin
            sdaOe   <= ~txSh_ff[6]; // (R19)
            txSh_ff <= {txSh_ff[6:0], 1'b0};
          end
        end
        sai_pkg::BS_MACK: begin
          if (sclRise) begin
            mackOk_ff <= ~sdaS;
          end else if (loadByte) begin
            busState_ff <= sai_pkg::BS_RDAT;
            txSh_ff     <= rdData;
            sdaOe       <= ~rdData[7];
            ptr_ff      <= ptr_ff + 8'h01; // (R22)
          end else if (sclFall) begin
            busState_ff <= sai_pkg::BS_IDLE;
          end
        end
        default: begin
          bitCnt_ff <= 4'h0;
        end
      endcase
    end
  end

  // open-drain data line only ever pulls low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    if (ptr_ff == sai_pkg::REG_TEMP_LO) begin
      rdData = tempReg_ff[7:0];
    end else if (ptr_ff == sai_pkg::REG_TEMP_HI) begin
      rdData = tempReg_ff[15:8];
    end else if (ptr_ff == sai_pkg::REG_HUM_LO) begin
      rdData = humReg_ff[7:0];
    end else if (ptr_ff == sai_pkg::REG_HUM_HI) begin
      rdData = humReg_ff[15:8];
    end else if (ptr_ff == sai_pkg::REG_FLAGS) begin
      rdData = flags_ff;
    end else if (ptr_ff == sai_pkg::REG_TEMP_MAX) begin
      rdData = tempMax_ff;
    end else if (ptr_ff == sai_pkg::REG_HUM_MAX) begin
      rdData = humMax_ff;
    end else if (isWritable(ptr_ff)) begin
      rdData = rwRegs_ff[ptr_ff[3:0]];
    end else if (ptr_ff == sai_pkg::REG_MFR_LO) begin
      rdData = MFR_ID[7:0];
    end else if (ptr_ff == sai_pkg::REG_MFR_HI) begin
      rdData = MFR_ID[15:8];
    end else if (ptr_ff == sai_pkg::REG_DEV_LO) begin
      rdData = DEV_ID[7:0];
    end else if (ptr_ff == sai_pkg::REG_DEV_HI) begin
      rdData = DEV_ID[15:8];
    end else begin
      rdData = 8'h00;
    end
  end

  // writable registers; trigger bit self-clears
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = sai_pkg::RW_LO; i <= sai_pkg::RW_HI; i++) begin
        rwRegs_ff[i] <= sai_pkg::RST_ZERO;
      end
      rwRegs_ff[sai_pkg::REG_HUM_LOWER[3:0]]  <= sai_pkg::RST_HUM_LOWER;
      rwRegs_ff[sai_pkg::REG_TEMP_UPPER[3:0]] <= sai_pkg::RST_TEMP_UPPER;
      rwRegs_ff[sai_pkg::REG_TEMP_LOWER[3:0]] <= sai_pkg::RST_TEMP_LOWER;
      rwRegs_ff[sai_pkg::REG_HUM_UPPER[3:0]]  <= sai_pkg::RST_HUM_UPPER;
    end else if (wrEn) begin
      rwRegs_ff[ptr_ff[3:0]] <= shReg_ff;
    end else if (measTrig) begin
      rwRegs_ff[sai_pkg::REG_MEAS_CFG[3:0]][sai_pkg::MEAS_TRIG] <= 1'b0;
    end
  end
  assign mask     = rwRegs_ff[sai_pkg::REG_MASK[3:0]];
  assign ctrl     = rwRegs_ff[sai_pkg::REG_CTRL[3:0]];
  assign measTrig = rwRegs_ff[sai_pkg::REG_MEAS_CFG[3:0]][sai_pkg::MEAS_TRIG];

  // sleep / measure sequencing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      measState_ff <= sai_pkg::MS_SLEEP;
      measStart    <= 1'b0;
      measBusy     <= 1'b0;
    end else begin
      measStart <= 1'b0;
      case (measState_ff)
        sai_pkg::MS_SLEEP: begin
          if (measTrig) begin
            measState_ff <= sai_pkg::MS_MEAS; // (R15)
            measStart    <= 1'b1;
            measBusy     <= 1'b1;
          end
        end
        default: begin
          if (convDone) begin
            measState_ff <= sai_pkg::MS_SLEEP; // (R15)
            measBusy     <= 1'b0;
          end
        end
      endcase
    end
  end
  assign convTake = convDone && (measState_ff == sai_pkg::MS_MEAS);

  // result storage and peak tracking
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tempReg_ff <= 16'h0000;
      humReg_ff  <= 16'h0000;
      tempMax_ff <= 8'h00;
      humMax_ff  <= 8'h00;
    end else if (convTake) begin
      tempReg_ff <= tempData; // (R15)
      humReg_ff  <= humidData;
      if (tempData[15:8] > tempMax_ff) begin
        tempMax_ff <= tempData[15:8];
      end
      if (humidData[15:8] > humMax_ff) begin
        humMax_ff <= humidData[15:8];
      end
    end
  end

  // threshold comparisons on the upper data byte
  assign cmpHit[3] = tempData[15:8]
                     > rwRegs_ff[sai_pkg::REG_TEMP_UPPER[3:0]]; // (R9)
  assign cmpHit[2] = tempData[15:8]
                     < rwRegs_ff[sai_pkg::REG_TEMP_LOWER[3:0]]; // (R10)
  assign cmpHit[1] = humidData[15:8]
                     > rwRegs_ff[sai_pkg::REG_HUM_UPPER[3:0]]; // (R11)
  assign cmpHit[0] = humidData[15:8]
                     < rwRegs_ff[sai_pkg::REG_HUM_LOWER[3:0]]; // (R12)

  // flags: read clears first, new events then win
  always_comb begin
    nxt_flags = flags_ff;
    if (statusRead) begin
      nxt_flags[sai_pkg::BIT_CONV] = 1'b0; // (R8)
      if (!ctrl[sai_pkg::CTRL_MODE]) begin
        nxt_flags[6:3] = 4'h0; // (R8) (R13)
      end
    end
    if (convTake) begin
      if (mask[sai_pkg::BIT_CONV]) begin
        nxt_flags[sai_pkg::BIT_CONV] = 1'b1; // (R4)
      end
      if (ctrl[sai_pkg::CTRL_MODE]) begin
        nxt_flags[6:3] = cmpHit & mask[6:3]; // (R14)
      end else begin
        nxt_flags[6:3] = nxt_flags[6:3] | (cmpHit & mask[6:3]); // (R13)
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  sai_alert u_alert (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .flags    (flags_ff),
    .mask     (mask),
    .ctrl     (ctrl),
    .alertOut (alertOut),
    .alertOe  (alertOe)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_addr_end;
    busState_ff == sai_pkg::BS_ADDR && byteDone && !stopCond && !startCond;
  endsequence
  sequence s_ptr_end;
    busState_ff == sai_pkg::BS_PTR && byteDone && !stopCond && !startCond;
  endsequence

  a_wrong_addr: assert property ( // (R22)
    s_addr_end ##0 (shReg_ff[7:1] != devAddr)
      |=> !sdaOe && busState_ff == sai_pkg::BS_IDLE)
    else $error("wrong address acknowledged");
  a_ptr_load: assert property ( // (R20)
    s_ptr_end ##0 isMapped(shReg_ff) |=> ptr_ff == $past(shReg_ff) && sdaOe)
    else $error("pointer byte not loaded");
  a_ptr_unused: assert property ( // (R22)
    s_ptr_end ##0 !isMapped(shReg_ff) |=> !sdaOe)
    else $error("unused pointer acknowledged");
  a_ro_nack: assert property ( // (R22)
    (busState_ff == sai_pkg::BS_WDAT && byteDone && !isWritable(ptr_ff)
      && !stopCond && !startCond) |=> !sdaOe)
    else $error("read-only write acknowledged");
  a_rd_incr: assert property ( // (R22)
    (loadByte && !stopCond && !startCond) |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("pointer not advanced on read");
  a_conv_set: assert property ( // (R4)
    (convTake && mask[sai_pkg::BIT_CONV]) |=> flags_ff[sai_pkg::BIT_CONV])
    else $error("data-ready flag not set");
  a_read_clear: assert property ( // (R8)
    (statusRead && !convTake) |=> !flags_ff[sai_pkg::BIT_CONV])
    else $error("status read left flag set");
  a_latch_hold: assert property ( // (R13)
    (!ctrl[sai_pkg::CTRL_MODE] && flags_ff[sai_pkg::BIT_TOVER] && !statusRead)
      |=> flags_ff[sai_pkg::BIT_TOVER])
    else $error("latched flag dropped");
  a_meas_cycle: assert property ( // (R15)
    (measState_ff == sai_pkg::MS_SLEEP && measTrig)
      |=> measStart && measBusy ##1 !measStart)
    else $error("measurement not started");
endmodule : sai_top

// >>> hdl/sai_pkg.sv
/*
  Shared constants for the sensor alert and two-wire register block:
  register offsets, field positions, reset values and state types.
  Assumes every design file of the block refers to it as sai_pkg::name.
*/
package sai_pkg;
  // register offsets
  localparam logic [7:0] REG_TEMP_LO    = 8'h00;
  localparam logic [7:0] REG_TEMP_HI    = 8'h01;
  localparam logic [7:0] REG_HUM_LO     = 8'h02;
  localparam logic [7:0] REG_HUM_HI     = 8'h03;
  localparam logic [7:0] REG_FLAGS      = 8'h04;
  localparam logic [7:0] REG_TEMP_MAX   = 8'h05;
  localparam logic [7:0] REG_HUM_MAX    = 8'h06;
  localparam logic [7:0] REG_MASK       = 8'h07;
  localparam logic [7:0] REG_HUM_LOWER  = 8'h0a;
  localparam logic [7:0] REG_TEMP_UPPER = 8'h0b;
  localparam logic [7:0] REG_TEMP_LOWER = 8'h0c;
  localparam logic [7:0] REG_HUM_UPPER  = 8'h0d;
  localparam logic [7:0] REG_CTRL       = 8'h0e;
  localparam logic [7:0] REG_MEAS_CFG   = 8'h0f;
  localparam logic [7:0] REG_MFR_LO     = 8'hfc;
  localparam logic [7:0] REG_MFR_HI     = 8'hfd;
  localparam logic [7:0] REG_DEV_LO     = 8'hfe;
  localparam logic [7:0] REG_DEV_HI     = 8'hff;
  // writable window, indices of the storage array
  localparam int RW_LO = 7;
  localparam int RW_HI = 15;
  // flag and mask bit positions (same in both registers)
  localparam int BIT_CONV   = 7;
  localparam int BIT_TOVER  = 6;
  localparam int BIT_TUNDER = 5;
  localparam int BIT_HOVER  = 4;
  localparam int BIT_HUNDER = 3;
  // control and measurement config register fields
  localparam int CTRL_PIN_EN = 2;
  localparam int CTRL_POL    = 1;
  localparam int CTRL_MODE   = 0;
  localparam int MEAS_TRIG   = 0;
  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_HUM_LOWER  = 8'h01;
  localparam logic [7:0] RST_TEMP_UPPER = 8'hff;
  localparam logic [7:0] RST_TEMP_LOWER = 8'h00;
  localparam logic [7:0] RST_HUM_UPPER  = 8'hff;
  // slave address, low bit from the select pin
  localparam logic [6:0] ADDR_BASE = 7'h40;
  localparam logic [1:0] ADDR_SETTLE = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic {MS_SLEEP, MS_MEAS} sai_meas_t;
  typedef enum logic [2:0] {
    BS_IDLE, BS_ADDR, BS_PTR, BS_WDAT, BS_ACK, BS_RDAT, BS_MACK
  } sai_bus_t;
endpackage : sai_pkg

// >>> hdl/sai_sync.sv
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes the inputs are quasi-static against core_clk.
*/
module sai_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // levels
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '1;
      syncOut <= '1;
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end
endmodule : sai_sync

// >>> hdl/sai_alert.sv
/*
  Alert pin driver: picks one interrupt source by fixed priority and
  drives the three-state push-pull pin with programmable polarity.
  Assumes flags, mask and control come from core_clk registers.
*/
module sai_alert (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // register state
  input  wire logic [7:0] flags,
  input  wire logic [7:0] mask,
  input  wire logic [7:0] ctrl,
  // pin
  output logic            alertOut,
  output logic            alertOe
);
  logic srcActive;
  logic pinOn;

  // one source only, highest enabled threshold wins
  always_comb begin
    if (mask[sai_pkg::BIT_TOVER]) begin // (R1) (R2)
      srcActive = flags[sai_pkg::BIT_TOVER];
    end else if (mask[sai_pkg::BIT_TUNDER]) begin // (R2)
      srcActive = flags[sai_pkg::BIT_TUNDER];
    end else if (mask[sai_pkg::BIT_HOVER]) begin // (R2)
      srcActive = flags[sai_pkg::BIT_HOVER];
    end else if (mask[sai_pkg::BIT_HUNDER]) begin // (R2)
      srcActive = flags[sai_pkg::BIT_HUNDER];
    end else if (mask[sai_pkg::BIT_CONV]) begin // (R3)
      srcActive = flags[sai_pkg::BIT_CONV];
    end else begin
      srcActive = 1'b0;
    end
  end

  assign pinOn = ctrl[sai_pkg::CTRL_PIN_EN] & ~ctrl[sai_pkg::CTRL_MODE];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alertOe  <= 1'b0;
      alertOut <= 1'b1;
    end else begin
      alertOe  <= pinOn; // (R5) (R6)
      alertOut <= srcActive ~^ ctrl[sai_pkg::CTRL_POL]; // (R7)
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_pin_hiz_off: assert property ( // (R6)
    !pinOn |=> !alertOe) else $error("alert pin driven while disabled");
  a_pin_on_cfg: assert property ( // (R5)
    alertOe |-> $past(ctrl[sai_pkg::CTRL_PIN_EN])
      && !$past(ctrl[sai_pkg::CTRL_MODE]))
    else $error("alert pin driven under wrong config");
  a_pol_level: assert property ( // (R7)
    (srcActive && !ctrl[sai_pkg::CTRL_POL]) |=> !alertOut)
    else $error("active low alert not low");
  a_prio_top: assert property ( // (R2)
    (mask[sai_pkg::BIT_TOVER] && ctrl[sai_pkg::CTRL_POL])
      |=> alertOut == $past(flags[sai_pkg::BIT_TOVER]))
    else $error("alert not following top source");
endmodule : sai_alert

// >>> dv/sai_bus_master.sv
/* two-wire bus master model, paced by core_clk, 160 ns bus clock
   assumes a pull-up on the data wire, device pulls via devPull */
module sai_bus_master (
  // pacing
  input  wire logic core_clk,
  // bus
  input  wire logic devPull,
  output logic      sclLine,
  output logic      sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mstPull = 1'b0;
  initial sclLine = 1'b1;
  // released wire floats to the pull-up level
  assign sdaLine = ~(mstPull | devPull);
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask : hold
  // also serves as repeated start from a low clock
  task automatic start;
    mstPull = 1'b0;
    hold(8);
    sclLine = 1'b1;
    hold(16);
    mstPull = 1'b1;
    hold(16);
    sclLine = 1'b0;
  endtask : start
  task automatic stop;
    hold(8);
    mstPull = 1'b1;
    hold(8);
    sclLine = 1'b1;
    hold(16);
    mstPull = 1'b0;
    hold(16);
  endtask : stop
  // data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    hold(8);
    mstPull = ~b;
    hold(8);
    sclLine = 1'b1;
    hold(16);
    r = sdaLine;
    sclLine = 1'b0;
  endtask : bitx
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~ackIt, r);
  endtask : rbyte
endmodule : sai_bus_master

// >>> dv/tb_sai_top.sv
/* bench for sai_top: master model on the bus, bench as converter
   assumes sai_pkg and the design files are compiled before it */
module tb_sai_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        convDone = 1'b0;
  logic [15:0] tempData = 16'h0000;
  logic [15:0] humidData = 16'h0000;
  logic        sclLine, sdaLine, sdaOe, measStart, measBusy;
  logic        alertOut, alertOe, ak, sdaOut;
  logic        addrSel = 1'b0;
  int          starts = 0;
  logic [7:0]  rv, rw;
  int          miscompares = 0;
  int          totalChecks = 0;
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (measStart) starts <= starts + 1;
  // strap only changes while reset is held
  sai_top sai_top_i (.core_clk(core_clk), .reset_n(reset_n),
    .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSel(addrSel), .convDone(convDone), .tempData(tempData),
    .humidData(humidData), .measStart(measStart),
    .measBusy(measBusy), .alertOut(alertOut), .alertOe(alertOe));
  sai_bus_master sai_bus_master_i (.core_clk(core_clk),
    .devPull(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] p, logic [7:0] d, output logic a);
    logic a0, a1;
    sai_bus_master_i.start;
    sai_bus_master_i.wbyte(8'h80, a0);
    sai_bus_master_i.wbyte(p, a1);
    sai_bus_master_i.wbyte(d, a);
    sai_bus_master_i.stop;
    a = a & a0 & a1;
  endtask : wr
  // pointer only, then repeated start and read
  task automatic rd(logic [7:0] p, int n, output logic [7:0] d, e);
    logic a;
    sai_bus_master_i.start;
    sai_bus_master_i.wbyte(8'h80, a);
    sai_bus_master_i.wbyte(p, a);
    sai_bus_master_i.start;
    sai_bus_master_i.wbyte(8'h81, a);
    sai_bus_master_i.rbyte(n > 1, d);
    if (n > 1) sai_bus_master_i.rbyte(1'b0, e);
    sai_bus_master_i.stop;
  endtask : rd
  task automatic conv(logic [15:0] t, logic [15:0] h);
    int n, s0;
    s0 = starts;
    wr(8'h0f, 8'h01, ak);
    for (n = 0; n < 50 && measBusy !== 1'b1; n++) @(negedge core_clk);
    chk("start", 8'h03, {6'h0, starts == s0 + 1, measBusy});
    tempData = t;
    humidData = h;
    convDone = 1'b1;
    @(negedge core_clk);
    convDone = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("busy", 8'h00, {7'h0, measBusy});
  endtask : conv
  task automatic t_reset;
    logic [7:0] p [5] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
    logic [7:0] e [5] = '{8'h01, 8'hff, 8'h00, 8'hff, 8'h00};
    chk("oe", 8'h00, {5'h0, sdaOut, alertOe, measBusy});
    foreach (p[i]) begin
      rd(p[i], 1, rv, rw);
      chk("rst", e[i], rv);
    end
  endtask : t_reset
  task automatic t_bus;
    logic a;
    sai_bus_master_i.start;
    sai_bus_master_i.wbyte(8'h82, a);
    sai_bus_master_i.stop;
    chk("badaddr", 8'h00, {7'h0, a});
    wr(8'h20, 8'h00, a);
    chk("unused", 8'h00, {7'h0, a});
    wr(8'hfc, 8'h00, a);
    chk("ro", 8'h00, {7'h0, a});
    sai_bus_master_i.start;
    sai_bus_master_i.wbyte(8'h80, a);
    sai_bus_master_i.wbyte(8'h0b, a);
    sai_bus_master_i.wbyte(8'h11, a);
    sai_bus_master_i.wbyte(8'h22, a);
    sai_bus_master_i.stop;
    chk("mack", 8'h01, {7'h0, a});
    rd(8'h0b, 2, rv, rw);
    chk("inc", 8'h22, rw);
    chk("first", 8'h11, rv);
  endtask : t_bus
  task automatic t_conversion_done;
    wr(8'h07, 8'h80, ak);
    wr(8'h0e, 8'h04, ak);
    conv(16'ha55a, 16'h3cc3);
    chk("pin", 8'h02, {6'h0, alertOe, alertOut});
    rd(8'h01, 1, rv, rw);
    chk("data", 8'ha5, rv);
    rd(8'h04, 1, rv, rw);
    chk("conversion_done", 8'h80, rv);
    chk("clr", 8'h01, {7'h0, alertOut});
  endtask : t_conversion_done
  task automatic t_prio;
    wr(8'h07, 8'h50, ak);
    wr(8'h0b, 8'h80, ak);
    wr(8'h0d, 8'h80, ak);
    wr(8'h0e, 8'h06, ak);
    conv(16'h1000, 16'h9000);
    chk("or", 8'h00, {7'h0, alertOut});
    conv(16'h9000, 16'h1000);
    chk("th", 8'h01, {7'h0, alertOut});
    conv(16'h1000, 16'h1000);
    rd(8'h04, 1, rv, rw);
    chk("latch", 8'h50, rv);
    chk("clr2", 8'h00, {7'h0, alertOut});
  endtask : t_prio
  task automatic t_comp;
    wr(8'h07, 8'h28, ak);
    wr(8'h0c, 8'h20, ak);
    wr(8'h0a, 8'h20, ak);
    wr(8'h0e, 8'h07, ak);
    chk("hiz", 8'h00, {7'h0, alertOe});
    conv(16'h1000, 16'h1000);
    rd(8'h04, 1, rv, rw);
    chk("under", 8'h28, rv);
    conv(16'h3000, 16'h3000);
    rd(8'h04, 1, rv, rw);
    chk("cmp", 8'h00, rv);
  endtask : t_comp
  // strap high selects the other address; needs a fresh reset
  task automatic t_strap;
    logic a, b;
    reset_n = 1'b0;
    addrSel = 1'b1;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge core_clk);
    sai_bus_master_i.start;
    sai_bus_master_i.wbyte(8'h80, b);
    sai_bus_master_i.stop;
    sai_bus_master_i.start;
    sai_bus_master_i.wbyte(8'h82, a);
    sai_bus_master_i.stop;
    chk("strap", 8'h01, {6'h0, b, a});
  endtask : t_strap
  task automatic summarize;
    if (miscompares == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (80000) @(posedge core_clk);
    miscompares++;
    summarize;
  end
  initial begin
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge core_clk);
    t_reset;
    t_bus;
    t_conversion_done;
    t_prio;
    t_comp;
    t_strap;
    summarize;
  end
endmodule : tb_sai_top
